// [rtl/bg2_consts.svh]
`ifndef BG2_CONSTS_SVH
`define BG2_CONSTS_SVH

// condition code bit positions inside the 4-bit flag word
`define BG2_FLAG_N 3
`define BG2_FLAG_Z 2
`define BG2_FLAG_V 1
`define BG2_FLAG_C 0

// execution lengths in machine clocks; mem compares, all decrement forms and both interrupt returns add the correction input
`define BG2_CMP1_TAKEN_CYC 5'h04
`define BG2_CMP1_FALL_CYC 5'h03
`define BG2_CMP2_TAKEN_CYC 5'h05
`define BG2_CMP2_FALL_CYC 5'h04
`define BG2_CMPM_TAKEN_CYC 5'h05
`define BG2_CMPM_FALL_CYC 5'h04
`define BG2_DEC_TAKEN_CYC 5'h06
`define BG2_DEC_FALL_CYC 5'h05
`define BG2_IRET_CYC 5'h06
`define BG2_FIRET_CYC 5'h06
`define BG2_FIRET_IRQ_CYC 5'h05
`define BG2_ENTER_CYC 5'h06
`define BG2_LEAVE_CYC 5'h05
`define BG2_NRET_CYC 5'h04
`define BG2_FRET_CYC 5'h06

// memory traffic per instruction
`define BG2_IRET_WORDS 4'h6
`define BG2_FIRQ_BYTES 4'h3
`define BG2_FIRQ_WORDS 4'h2

`endif

// [rtl/bg2_pkg.sv]
package bg2_pkg;

  typedef enum logic [3:0] {
    BG2_CMP_ACC_B = 4'h0,
    BG2_CMP_ACC_W = 4'h1,
    BG2_CMP_REG_B = 4'h2,
    BG2_CMP_MEM_B = 4'h3,
    BG2_CMP_REG_W = 4'h4,
    BG2_CMP_MEM_W = 4'h5,
    BG2_DEC_REG_B = 4'h6,
    BG2_DEC_MEM_B = 4'h7,
    BG2_DEC_REG_W = 4'h8,
    BG2_DEC_MEM_W = 4'h9,
    BG2_IRET = 4'ha,
    BG2_FAST_IRET = 4'hb,
    BG2_FRAME_ENTER = 4'hc,
    BG2_FRAME_LEAVE = 4'hd,
    BG2_NEAR_RET = 4'he,
    BG2_FAR_RET = 4'hf
  } bg2_op_e;

endpackage

// [rtl/bg2_alu_if.sv]
`timescale 1ns/1ps
interface bg2_alu_if;
  logic word;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] res;
  logic n;
  logic z;
  logic v;
  logic c;
  modport calc (input word, input a, input b, output res, output n, output z, output v, output c);
  modport user (output word, output a, output b, input res, input n, input z, input v, input c);
endinterface

// [rtl/bg2_sub_alu.sv]
`timescale 1ns/1ps
// a minus b on a byte or a word, with the four condition codes
module bg2_sub_alu (
  bg2_alu_if.calc p
);
  logic [16:0] diff;
  logic sa;
  logic sb;
  logic sr;

  always_comb
  begin
    diff = {1'b0, p.a} - {1'b0, p.b};
    if (p.word)
    begin
      p.res = diff[15:0];
      sa = p.a[15];
      sb = p.b[15];
      sr = diff[15];
      p.c = diff[16];
      p.z = (diff[15:0] == 16'h0000);
    end
    else
    begin
      p.res = {8'h00, diff[7:0]};
      sa = p.a[7];
      sb = p.b[7];
      sr = diff[7];
      // byte borrow comes from comparing the two low bytes, set when a is below b
      p.c = (p.a[7:0] < p.b[7:0]);
      p.z = (diff[7:0] == 8'h00);
    end
    p.n = sr;
    p.v = (sa ^ sb) & (sa ^ sr);
  end
endmodule

// [rtl/bg2_exec.sv]
// What this block does
// - accumulator byte compare with imm8 branches when unequal and sets N, Z, V, C.
// - accumulator word compare with imm16 branches when unequal and sets N, Z, V, C.
// - byte compare also takes a register or memory operand against imm8, same branch and flags.
// - word compare of a register or memory operand against imm16 branches when unequal and sets N, Z, V, C.
// - accumulator and byte-register compares take 4 clocks when taken and 3 when not.
// - word-register compares take 5 clocks when taken and 4 when not.
// - memory compares take 5 plus correction when taken and 4 plus correction when not.
// - decrement-branch forms take 6 plus correction when taken and 5 plus correction when not.
// - byte decrement writes back operand minus one, branches on nonzero, sets N, Z, V and keeps C.
// - word decrement branches on nonzero and locks the bus for its memory read-modify-write.
// - fast interrupt return does 3 byte and 2 word accesses on a pending request, else 6 word accesses.
// - a request seen during fast interrupt return jumps to its vector with no stack restore or save.
// - near return pops a 16-bit pc; far return pops a long word restoring pc and code bank.
`timescale 1ns/1ps
`include "bg2_consts.svh"
module bg2_exec #(
  parameter int CORR_W = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire bg2_pkg::bg2_op_e op_i,
  input wire logic [15:0] acc_i,
  input wire logic [15:0] opnd_i,
  input wire logic [15:0] imm_i,
  input wire logic [7:0] disp_i,
  input wire logic [15:0] pc_next_i,
  input wire logic [CORR_W-1:0] corr_i,
  input wire logic [3:0] flags_i,
  input wire logic irq_i,
  input wire logic [15:0] vector_i,
  input wire logic [15:0] sp_i,
  input wire logic [15:0] fp_i,
  input wire logic [15:0] pop_word_i,
  input wire logic [7:0] pop_bank_i,
  output logic busy_o,
  output logic done_o,
  output logic taken_o,
  output logic [15:0] pc_o,
  output logic pc_we_o,
  output logic [7:0] pcb_o,
  output logic pcb_we_o,
  output logic [3:0] flags_o,
  output logic flags_we_o,
  output logic wb_en_o,
  output logic [15:0] wb_data_o,
  output logic lock_o,
  output logic [15:0] sp_o,
  output logic [15:0] fp_o,
  output logic [3:0] byte_acc_o,
  output logic [3:0] word_acc_o
);
  bg2_alu_if alu ();
  bg2_sub_alu u_alu (.p(alu));

  logic busy_ff, done_ff, taken_ff, pc_we_ff, pcb_we_ff, flags_we_ff, wb_en_ff, wb_pend_ff, lock_ff;
  logic nxt_busy, nxt_done, nxt_taken, nxt_pc_we, nxt_pcb_we, nxt_flags_we, nxt_wb_en, nxt_wb_pend, nxt_lock;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] pc_ff, nxt_pc, wb_ff, nxt_wb, sp_ff, nxt_sp, fp_ff, nxt_fp;
  logic [7:0] pcb_ff, nxt_pcb;
  logic [3:0] flags_ff, nxt_flags, bytes_ff, nxt_bytes, words_ff, nxt_words;
  logic is_cmp, is_dec, is_word, cond;
  logic [4:0] corr5, len;
  logic [15:0] target;

  assign corr5 = 5'(corr_i);
  assign target = pc_next_i + {{8{disp_i[7]}}, disp_i};

  always_comb
  begin
    is_cmp = (op_i <= bg2_pkg::BG2_CMP_MEM_W);
    is_dec = (op_i >= bg2_pkg::BG2_DEC_REG_B) && (op_i <= bg2_pkg::BG2_DEC_MEM_W);
    is_word = (op_i == bg2_pkg::BG2_CMP_ACC_W) || (op_i == bg2_pkg::BG2_CMP_REG_W) ||
              (op_i == bg2_pkg::BG2_CMP_MEM_W) || (op_i == bg2_pkg::BG2_DEC_REG_W) ||
              (op_i == bg2_pkg::BG2_DEC_MEM_W);
    alu.word = is_word;
    alu.a = (op_i == bg2_pkg::BG2_CMP_ACC_B || op_i == bg2_pkg::BG2_CMP_ACC_W) ? acc_i : opnd_i;
    alu.b = is_dec ? 16'h0001 : imm_i;
  end

  // kept apart from the operand mux so the alu round trip does not re-enter one process
  assign cond = !alu.z;

  // length of the instruction once the branch outcome is known
  always_comb
  begin
    case (op_i)
      bg2_pkg::BG2_CMP_ACC_B, bg2_pkg::BG2_CMP_ACC_W, bg2_pkg::BG2_CMP_REG_B:
        len = cond ? `BG2_CMP1_TAKEN_CYC : `BG2_CMP1_FALL_CYC;
      bg2_pkg::BG2_CMP_REG_W:
        len = cond ? `BG2_CMP2_TAKEN_CYC : `BG2_CMP2_FALL_CYC;
      bg2_pkg::BG2_CMP_MEM_B, bg2_pkg::BG2_CMP_MEM_W:
        len = (cond ? `BG2_CMPM_TAKEN_CYC : `BG2_CMPM_FALL_CYC) + corr5;
      bg2_pkg::BG2_DEC_REG_B, bg2_pkg::BG2_DEC_MEM_B, bg2_pkg::BG2_DEC_REG_W, bg2_pkg::BG2_DEC_MEM_W:
        len = (cond ? `BG2_DEC_TAKEN_CYC : `BG2_DEC_FALL_CYC) + corr5;
      bg2_pkg::BG2_IRET: len = `BG2_IRET_CYC + corr5;
      bg2_pkg::BG2_FAST_IRET: len = (irq_i ? `BG2_FIRET_IRQ_CYC : `BG2_FIRET_CYC) + corr5;
      bg2_pkg::BG2_FRAME_ENTER: len = `BG2_ENTER_CYC;
      bg2_pkg::BG2_FRAME_LEAVE: len = `BG2_LEAVE_CYC;
      bg2_pkg::BG2_NEAR_RET: len = `BG2_NRET_CYC;
      bg2_pkg::BG2_FAR_RET: len = `BG2_FRET_CYC;
      default: len = `BG2_CMP1_FALL_CYC;
    endcase
  end

  always_comb
  begin
    nxt_busy = busy_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_wb_en = 1'b0;
    nxt_wb_pend = wb_pend_ff;
    nxt_lock = busy_ff ? lock_ff : 1'b0;
    nxt_taken = taken_ff;
    nxt_pc = pc_ff;
    nxt_pc_we = pc_we_ff;
    nxt_pcb = pcb_ff;
    nxt_pcb_we = pcb_we_ff;
    nxt_flags = flags_ff;
    nxt_flags_we = flags_we_ff;
    nxt_wb = wb_ff;
    nxt_sp = sp_ff;
    nxt_fp = fp_ff;
    nxt_bytes = bytes_ff;
    nxt_words = words_ff;
    if (busy_ff)
    begin
      nxt_cnt = cnt_ff - 5'h01;
      if (cnt_ff == 5'h01)
      begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        // lock stands through the done cycle so the write-back is still covered
        nxt_wb_en = wb_pend_ff;
      end
    end
    else if (start_i)
    begin
      // results are settled at issue and held; done marks the end of the instruction time
      nxt_busy = 1'b1;
      // the done cycle is the last of len clocks, so a new take can land on it
      nxt_cnt = len - 5'h01;
      nxt_taken = 1'b0;
      nxt_pc = pc_next_i;
      nxt_pc_we = 1'b0;
      nxt_pcb = pop_bank_i;
      nxt_pcb_we = 1'b0;
      nxt_flags = flags_i;
      nxt_flags_we = 1'b0;
      nxt_wb = alu.res;
      nxt_wb_pend = 1'b0;
      nxt_lock = 1'b0;
      nxt_sp = sp_i;
      nxt_fp = fp_i;
      nxt_bytes = 4'h0;
      nxt_words = 4'h0;
      if (is_cmp)
      begin
        nxt_taken = cond;
        nxt_pc = cond ? target : pc_next_i;
        nxt_pc_we = 1'b1;
        nxt_flags = {alu.n, alu.z, alu.v, alu.c};
        nxt_flags_we = 1'b1;
        if (op_i == bg2_pkg::BG2_CMP_MEM_B || op_i == bg2_pkg::BG2_CMP_MEM_W)
        begin
          nxt_bytes = is_word ? 4'h0 : 4'h1;
          nxt_words = is_word ? 4'h1 : 4'h0;
        end
      end
      else if (is_dec)
      begin
        nxt_taken = cond;
        nxt_pc = cond ? target : pc_next_i;
        nxt_pc_we = 1'b1;
        nxt_flags = {alu.n, alu.z, alu.v, flags_i[`BG2_FLAG_C]};
        nxt_flags_we = 1'b1;
        nxt_wb_pend = 1'b1;
        // memory forms hold the bus from read to write so nothing slips in between
        if (op_i == bg2_pkg::BG2_DEC_MEM_B || op_i == bg2_pkg::BG2_DEC_MEM_W)
        begin
          nxt_lock = 1'b1;
          nxt_bytes = is_word ? 4'h0 : 4'h2;
          nxt_words = is_word ? 4'h2 : 4'h0;
        end
      end
      else
      begin
        case (op_i)
          bg2_pkg::BG2_IRET:
          begin
            nxt_pc = pop_word_i;
            nxt_pc_we = 1'b1;
            nxt_pcb_we = 1'b1;
            nxt_words = `BG2_IRET_WORDS;
          end
          bg2_pkg::BG2_FAST_IRET:
          begin
            nxt_pc_we = 1'b1;
            if (irq_i)
            begin
              nxt_pc = vector_i;
              nxt_bytes = `BG2_FIRQ_BYTES;
              nxt_words = `BG2_FIRQ_WORDS;
            end
            else
            begin
              nxt_pc = pop_word_i;
              nxt_pcb_we = 1'b1;
              nxt_words = `BG2_IRET_WORDS;
            end
          end
          bg2_pkg::BG2_FRAME_ENTER:
          begin
            nxt_fp = sp_i - 16'h0002;
            nxt_sp = sp_i - 16'h0002 - {8'h00, imm_i[7:0]};
            nxt_words = 4'h1;
          end
          bg2_pkg::BG2_FRAME_LEAVE:
          begin
            nxt_fp = pop_word_i;
            nxt_sp = fp_i + 16'h0002;
            nxt_words = 4'h1;
          end
          bg2_pkg::BG2_NEAR_RET:
          begin
            nxt_pc = pop_word_i;
            nxt_pc_we = 1'b1;
            nxt_sp = sp_i + 16'h0002;
            nxt_words = 4'h1;
          end
          bg2_pkg::BG2_FAR_RET:
          begin
            nxt_pc = pop_word_i;
            nxt_pc_we = 1'b1;
            nxt_pcb_we = 1'b1;
            nxt_sp = sp_i + 16'h0004;
            nxt_words = 4'h2;
          end
          default:
          begin
            nxt_pc_we = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 5'h00;
      done_ff <= 1'b0;
      wb_en_ff <= 1'b0;
      wb_pend_ff <= 1'b0;
      lock_ff <= 1'b0;
      taken_ff <= 1'b0;
      pc_ff <= 16'h0000;
      pc_we_ff <= 1'b0;
      pcb_ff <= 8'h00;
      pcb_we_ff <= 1'b0;
      flags_ff <= 4'h0;
      flags_we_ff <= 1'b0;
      wb_ff <= 16'h0000;
      sp_ff <= 16'h0000;
      fp_ff <= 16'h0000;
      bytes_ff <= 4'h0;
      words_ff <= 4'h0;
    end
    else
    begin
      busy_ff <= nxt_busy;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      wb_en_ff <= nxt_wb_en;
      wb_pend_ff <= nxt_wb_pend;
      lock_ff <= nxt_lock;
      taken_ff <= nxt_taken;
      pc_ff <= nxt_pc;
      pc_we_ff <= nxt_pc_we;
      pcb_ff <= nxt_pcb;
      pcb_we_ff <= nxt_pcb_we;
      flags_ff <= nxt_flags;
      flags_we_ff <= nxt_flags_we;
      wb_ff <= nxt_wb;
      sp_ff <= nxt_sp;
      fp_ff <= nxt_fp;
      bytes_ff <= nxt_bytes;
      words_ff <= nxt_words;
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign taken_o = taken_ff;
  assign pc_o = pc_ff;
  assign pc_we_o = pc_we_ff;
  assign pcb_o = pcb_ff;
  assign pcb_we_o = pcb_we_ff;
  assign flags_o = flags_ff;
  assign flags_we_o = flags_we_ff;
  assign wb_en_o = wb_en_ff;
  assign wb_data_o = wb_ff;
  assign lock_o = lock_ff;
  assign sp_o = sp_ff;
  assign fp_o = fp_ff;
  assign byte_acc_o = bytes_ff;
  assign word_acc_o = words_ff;

  logic take;
  assign take = start_i && !busy_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_accb_taken: assert property (
    take && op_i == bg2_pkg::BG2_CMP_ACC_B && acc_i[7:0] != imm_i[7:0]
    |=> !done_o [*3] ##1 (done_o && taken_o && pc_o == $past(target, 4)))
    else $error("accumulator byte compare did not branch in 4 clocks");
  a_accw_equal: assert property (
    take && op_i == bg2_pkg::BG2_CMP_ACC_W && acc_i == imm_i
    |-> ##3 (done_o && !taken_o && flags_o[`BG2_FLAG_Z] && !flags_o[`BG2_FLAG_C]))
    else $error("equal word compare branched or flags wrong");
  a_regb_time: assert property (
    take && op_i == bg2_pkg::BG2_CMP_REG_B && opnd_i[7:0] == imm_i[7:0] |-> ##3 (done_o && !taken_o))
    else $error("byte register compare not-taken time wrong");
  a_regw_time: assert property (
    take && op_i == bg2_pkg::BG2_CMP_REG_W && opnd_i != imm_i |=> !done_o [*4] ##1 (done_o && taken_o))
    else $error("word register compare taken time wrong");
  a_memb_time: assert property (
    take && op_i == bg2_pkg::BG2_CMP_MEM_B && corr_i == 4'h2 && opnd_i[7:0] != imm_i[7:0] |-> ##7 done_o)
    else $error("memory compare time wrong");
  a_decb_carry: assert property (
    take && op_i == bg2_pkg::BG2_DEC_REG_B && opnd_i[7:0] == 8'h01 && corr_i == 4'h0
    |-> ##5 (done_o && wb_en_o && !taken_o && flags_o[`BG2_FLAG_Z] &&
             flags_o[`BG2_FLAG_C] == $past(flags_i[`BG2_FLAG_C], 5)))
    else $error("byte decrement result, time or carry wrong");
  a_decw_lock: assert property (
    take && op_i == bg2_pkg::BG2_DEC_MEM_W |=> lock_o [*5])
    else $error("word memory decrement not locked");
  a_fast_irq: assert property (
    take && op_i == bg2_pkg::BG2_FAST_IRET && irq_i
    |=> (pc_o == $past(vector_i) && pc_we_o && !pcb_we_o && sp_o == $past(sp_i) &&
         byte_acc_o == 4'h3 && word_acc_o == 4'h2))
    else $error("fast return did not jump to the vector");
  a_leave_time: assert property (
    take && op_i == bg2_pkg::BG2_FRAME_LEAVE |-> ##5 (done_o && fp_o == $past(pop_word_i, 5)))
    else $error("frame leave timing or pop wrong");
  a_near_ret: assert property (
    take && op_i == bg2_pkg::BG2_NEAR_RET |=> (pc_o == $past(pop_word_i) && sp_o == $past(sp_i) + 16'h0002))
    else $error("near return did not pop the pc");

  c_cmp_taken: cover property (take && is_cmp ##[3:20] (done_o && taken_o));
  c_dec_mem: cover property (take && op_i == bg2_pkg::BG2_DEC_MEM_B ##[5:20] wb_en_o);
  c_fast_irq: cover property (take && op_i == bg2_pkg::BG2_FAST_IRET && irq_i);
  c_back_to_back: cover property (done_o && take);
endmodule

// [test/bg2_mem_model.sv]
`timescale 1ns/1ps
// stack side of data memory: the word at sp, and the bank byte of the word above it
module bg2_mem_model (
  input wire logic [15:0] sp_i,
  output logic [15:0] pop_word_o,
  output logic [7:0] pop_bank_o
);
  logic [15:0] ram [0:127];
  // unloaded words read back as a shifting pattern rather than a tidy zero
  initial
  begin
    for (int i = 0; i < 128; i++)
      ram[i] = 16'hA5C3 ^ 16'(i * 7);
  end
  assign pop_word_o = ram[sp_i[7:1]];
  assign pop_bank_o = ram[sp_i[7:1] + 7'h01][7:0];
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic start_i = 1'b0;
  bg2_pkg::bg2_op_e op_i = bg2_pkg::BG2_CMP_ACC_B;
  logic [15:0] acc_i = 16'h0000;
  logic [15:0] opnd_i = 16'h0000;
  logic [15:0] imm_i = 16'h0000;
  logic [7:0] disp_i = 8'hFE;
  logic [3:0] corr_i = 4'h2;
  logic [3:0] flags_i = 4'h0;
  logic irq_i = 1'b0;
  logic [15:0] pop_word, sp_o, fp_o, pc_o, wb_data_o;
  logic [7:0] pop_bank, pcb_o;
  logic busy_o, done_o, taken_o, pc_we_o, pcb_we_o, flags_we_o, wb_en_o, lock_o;
  logic [3:0] flags_o, byte_acc_o, word_acc_o;
  int fails = 0;
  int comparisons = 0;
  int len;
  logic lock_seen, wb_seen;

  bg2_exec u_bg2_exec (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .op_i(op_i), .acc_i(acc_i),
    .opnd_i(opnd_i), .imm_i(imm_i), .disp_i(disp_i), .pc_next_i(16'h1000), .corr_i(corr_i),
    .flags_i(flags_i), .irq_i(irq_i), .vector_i(16'h2468), .sp_i(16'h0040), .fp_i(16'h0080),
    .pop_word_i(pop_word), .pop_bank_i(pop_bank), .busy_o(busy_o), .done_o(done_o), .taken_o(taken_o),
    .pc_o(pc_o), .pc_we_o(pc_we_o), .pcb_o(pcb_o), .pcb_we_o(pcb_we_o), .flags_o(flags_o),
    .flags_we_o(flags_we_o), .wb_en_o(wb_en_o), .wb_data_o(wb_data_o), .lock_o(lock_o), .sp_o(sp_o),
    .fp_o(fp_o), .byte_acc_o(byte_acc_o), .word_acc_o(word_acc_o));
  bg2_mem_model u_bg2_mem_model (.sp_i(16'h0040), .pop_word_o(pop_word), .pop_bank_o(pop_bank));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [3:0] flg(input logic [15:0] a, input logic [15:0] b, input logic w);
    logic [16:0] d;
    logic [3:0] f;
    d = {1'b0, a} - {1'b0, b};
    f = {d[15], d[15:0] == 16'h0000, (a[15] ^ b[15]) & (a[15] ^ d[15]), d[16]};
    if (!w)
    begin
      d = {9'h000, a[7:0]} - {9'h000, b[7:0]};
      f = {d[7], d[7:0] == 8'h00, (a[7] ^ b[7]) & (a[7] ^ d[7]), d[8]};
    end
    return f;
  endfunction

  // entered at a falling edge; returns at the falling edge inside the done cycle, length in len
  task automatic issue(input bg2_pkg::bg2_op_e op, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] m);
    op_i = op;
    acc_i = a;
    opnd_i = b;
    imm_i = m;
    start_i = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    start_i = 1'b0;
    len = 0;
    for (int i = 1; i <= 20; i++)
    begin
      @(negedge clk_i);
      if (i == 1)
        lock_seen = lock_o;
      if (done_o === 1'b1)
      begin
        len = i + 1;
        wb_seen = wb_en_o;
        break;
      end
    end
    if (len == 0)
    begin
      fails++;
      $display("ERROR %0t: no completion", $time);
      stop_test();
    end
  endtask

  task automatic t_cmp_acc();
    issue(bg2_pkg::BG2_CMP_ACC_B, 16'hAB12, 16'h0000, 16'h0034);
    chk(len, 4);
    chk({taken_o, pc_we_o, flags_we_o}, 3'h7);
    chk(pc_o, 16'h0FFE);
    chk(flags_o, flg(16'hAB12, 16'h0034, 1'b0));
    disp_i = 8'h10;
    issue(bg2_pkg::BG2_CMP_ACC_W, 16'h8000, 16'h0000, 16'h0001);
    chk(len, 4);
    chk(pc_o, 16'h1010);
    chk(flags_o, flg(16'h8000, 16'h0001, 1'b1));
    disp_i = 8'hFE;
    // upper byte differs but the byte form must ignore it
    issue(bg2_pkg::BG2_CMP_ACC_B, 16'hFF55, 16'h0000, 16'h0055);
    chk(len, 3);
    chk(taken_o, 1'b0);
    chk(flags_o, flg(16'hFF55, 16'h0055, 1'b0));
    issue(bg2_pkg::BG2_CMP_ACC_W, 16'h1234, 16'h0000, 16'h1234);
    chk(len, 3);
    chk(taken_o, 1'b0);
    chk(flags_o, 4'h4);
  endtask

  task automatic t_cmp_opnd();
    bg2_pkg::bg2_op_e ops [4] = '{bg2_pkg::BG2_CMP_REG_B, bg2_pkg::BG2_CMP_MEM_B, bg2_pkg::BG2_CMP_REG_W,
      bg2_pkg::BG2_CMP_MEM_W};
    int base [4] = '{4, 5, 5, 5};
    for (int i = 0; i < 4; i++)
    begin
      issue(ops[i], 16'h0000, 16'h1280, 16'h1301);
      chk(len, base[i] + (i % 2) * 2);
      chk(taken_o, 1'b1);
      chk(flags_o, flg(16'h1280, 16'h1301, i >= 2));
      issue(ops[i], 16'h0000, 16'h4321, 16'h4321);
      chk(len, base[i] - 1 + (i % 2) * 2);
      chk(taken_o, 1'b0);
    end
  endtask

  task automatic t_dec();
    bg2_pkg::bg2_op_e ops [4] = '{bg2_pkg::BG2_DEC_REG_B, bg2_pkg::BG2_DEC_MEM_B, bg2_pkg::BG2_DEC_REG_W,
      bg2_pkg::BG2_DEC_MEM_W};
    logic [15:0] msk;
    logic [3:0] f;
    flags_i = 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      msk = (i >= 2) ? 16'hFFFF : 16'h00FF;
      f = flg(16'h0080, 16'h0001, i >= 2);
      issue(ops[i], 16'h0000, 16'h0080, 16'h0000);
      chk(len, 8);
      chk({taken_o, wb_seen}, 2'h3);
      chk(wb_data_o & msk, 16'h007F);
      chk(flags_o, {f[3:1], 1'b1});
      chk(lock_seen, i % 2);
      issue(ops[i], 16'h0000, 16'h0001, 16'h0000);
      chk(len, 7);
      chk(taken_o, 1'b0);
    end
    corr_i = 4'h0;
    issue(bg2_pkg::BG2_DEC_REG_B, 16'h0000, 16'h0001, 16'h0000);
    chk(len, 5);
    chk(flags_o, 4'h5);
    corr_i = 4'h2;
    flags_i = 4'h0;
  endtask

  task automatic t_iret();
    corr_i = 4'h3;
    irq_i = 1'b1;
    issue(bg2_pkg::BG2_FAST_IRET, 16'h0000, 16'h0000, 16'h0000);
    chk(len, 8);
    chk({byte_acc_o, word_acc_o}, 8'h32);
    chk(pc_o, 16'h2468);
    irq_i = 1'b0;
    issue(bg2_pkg::BG2_FAST_IRET, 16'h0000, 16'h0000, 16'h0000);
    chk(len, 9);
    chk({byte_acc_o, word_acc_o}, 8'h06);
    corr_i = 4'h2;
  endtask

  task automatic t_ret();
    u_bg2_mem_model.ram[32] = 16'h1B2C;
    u_bg2_mem_model.ram[33] = 16'h0077;
    issue(bg2_pkg::BG2_NEAR_RET, 16'h0000, 16'h0000, 16'h0000);
    chk(len, 4);
    chk({pc_we_o, pc_o}, 17'h1_1B2C);
    issue(bg2_pkg::BG2_FAR_RET, 16'h0000, 16'h0000, 16'h0000);
    chk(len, 6);
    chk({pcb_we_o, pcb_o, pc_o}, 25'h177_1B2C);
    issue(bg2_pkg::BG2_IRET, 16'h0000, 16'h0000, 16'h0000);
    chk(len, 8);
    chk({pc_we_o, pcb_we_o, pcb_o, pc_o}, 26'h377_1B2C);
    chk({word_acc_o, flags_we_o}, 5'h0C);
  endtask

  task automatic t_frame();
    issue(bg2_pkg::BG2_FRAME_ENTER, 16'h0000, 16'h0000, 16'hFF10);
    chk(len, 6);
    chk({fp_o, sp_o}, 32'h003E_002E);
    issue(bg2_pkg::BG2_FRAME_LEAVE, 16'h0000, 16'h0000, 16'h0000);
    chk(len, 5);
    chk({fp_o, sp_o}, 32'h1B2C_0082);
  endtask

  initial
  begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    chk({busy_o, done_o, pc_we_o, flags_o}, 7'h00);
    t_cmp_acc();
    t_cmp_opnd();
    t_dec();
    t_iret();
    t_ret();
    t_frame();
    stop_test();
  end
endmodule
